/* File: bench/lcm_frame_ctrl_properties.sv */
// Port checker for the display frame controller
`timescale 1ns/10ps
module lcm_frame_ctrl_properties
  import lcm_pkg::*;
(
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  // Register bus
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  // Status and panel
  input wire logic        osc_fail_in,
  input wire logic [44:0] segment_line_out,
  input wire logic [3:0]  backplane_outputs_out,
  input wire logic        frame_phase_out,
  input wire logic        drive_en_out,
  input wire logic        bias_third_en_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  chk_ready_pair: assert property (
    s_axi_awready_out == s_axi_wready_out)
    else $error("write readies differ");
  chk_write_answer: assert property (
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    |=> s_axi_bvalid_out) else $error("no write answer");
  chk_read_answer: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("no read answer");
  chk_bresp_stands: assert property (
    s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("bresp moved");
  chk_rdata_stands: assert property (
    s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("rdata moved");
  chk_off_grounded: assert property (
    !drive_en_out && $past(!drive_en_out)
    |-> segment_line_out == '0 && backplane_outputs_out == 4'h0
    && !frame_phase_out) else $error("lines up while off");
  chk_bias_off: assert property (!drive_en_out |-> !bias_third_en_out)
    else $error("bias on while off");
  chk_one_plate: assert property (drive_en_out
    |-> $onehot(backplane_outputs_out)) else $error("plates not one-hot");
  chk_fail_off: assert property (
    osc_fail_in |-> ##[1:2] !drive_en_out)
    else $error("fail did not stop drive");
  chk_plate_order: assert property (
    drive_en_out && $past(drive_en_out)
    && !$stable(backplane_outputs_out) |-> backplane_outputs_out == 4'h1
    || backplane_outputs_out == 4'($past(backplane_outputs_out) << 1))
    else $error("plate order broken");
endmodule // lcm_frame_ctrl_properties

/* File: bench/lcm_panel_model.sv */
// Panel model: keeps the image each backplane last showed
`timescale 1ns/10ps
module lcm_panel_model
  import lcm_pkg::*;
(
  // Clock and panel lines
  input  wire logic        clk_in,
  input  wire logic [44:0] seg_in,
  input  wire logic [3:0]  plate_in,
  input  wire logic        drive_in,
  // Image seen per backplane
  output logic [44:0]      lit_out [4]
);
  // Glass only holds what a selected plate saw while driven
  always_ff @(posedge clk_in) begin
    for (int g = 0; g < 4; g++) begin
      if (drive_in && plate_in[g]) begin
        lit_out[g] <= seg_in;
      end
    end
  end
endmodule // lcm_panel_model

/* File: bench/tb_top.sv */
// Self-checking bench for the display frame controller
`timescale 1ns/10ps
module tb_top;
  import lcm_pkg::*;
  // ==========================================================
  // Signals
  logic        clk_in = 0, sys_rst_in = 1;
  logic [11:0] aw_a = 0, ar_a = 0;
  logic        aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
  logic [31:0] w_d = 0, rd;
  logic        stop_q = 0, fail_q = 0, aux_q = 0;
  logic        awr, wr, bv, arr, rv, phase, drv, bias;
  logic [1:0]  br, rr;
  logic [44:0] seg;
  logic [3:0]  plate;
  logic [44:0] lit [4];
  int          error_cnt = 0;
  int          num_checks = 0;
  int          stall = 0;
  int          ticks [7] = '{512, 384, 256, 192, 128, 96, 64};
  always #25 clk_in = ~clk_in;
  // Slow oscillator: one rising edge every two clocks
  always @(posedge clk_in) aux_q <= ~aux_q;
  lcm_frame_ctrl DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v),
    .s_axi_awready_out(awr), .s_axi_wdata_in(w_d),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(w_v), .s_axi_wready_out(wr),
    .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(b_r),
    .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(r_r), .stop_mode_in(stop_q),
    .osc_fail_in(fail_q), .aux_slow_oscillator_in(aux_q),
    .segment_line_out(seg), .backplane_outputs_out(plate),
    .frame_phase_out(phase), .drive_en_out(drv),
    .bias_third_en_out(bias));
  lcm_panel_model u_panel (.clk_in(clk_in), .seg_in(seg),
    .plate_in(plate), .drive_in(drv), .lit_out(lit));
  // ==========================================================
  // Helpers
  task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic axi_wr(logic [7:0] i, logic [7:0] d, logic [1:0] e);
    @(posedge clk_in);
    aw_a <= {2'b00, i, 2'b00};
    w_d <= {24'h00_0000, d};
    aw_v <= 1;
    w_v <= 1;
    b_r <= (stall == 0);
    do @(negedge clk_in); while (!(awr && wr));
    @(posedge clk_in);
    aw_v <= 0;
    w_v <= 0;
    do @(negedge clk_in); while (!bv);
    // Late ready makes the response stand for a few cycles
    if (stall > 0) begin
      repeat (stall) @(posedge clk_in);
      b_r <= 1;
      @(negedge clk_in);
    end
    check("bresp", br, e);
    @(posedge clk_in);
    b_r <= 0;
  endtask
  task automatic axi_rd(logic [7:0] i, logic [7:0] d, logic [1:0] e);
    @(posedge clk_in);
    ar_a <= {2'b00, i, 2'b00};
    ar_v <= 1;
    r_r <= (stall == 0);
    do @(negedge clk_in); while (!arr);
    @(posedge clk_in);
    ar_v <= 0;
    do @(negedge clk_in); while (!rv);
    if (stall > 0) begin
      repeat (stall) @(posedge clk_in);
      r_r <= 1;
      @(negedge clk_in);
    end
    check("rdata", {rr, rd}, {e, 24'h00_0000, d});
    @(posedge clk_in);
    r_r <= 0;
  endtask
  function automatic logic [7:0] pat(int a);
    return 8'(a * 8'h25 + 8'h5B);
  endfunction
  function automatic logic [44:0] segs(int g);
    logic [47:0] v;
    for (int k = 0; k < 6; k++) v[8*k +: 8] = pat(6 * g + k);
    return v[47:3];
  endfunction
  // Length of one whole frame, with every plate seen in it
  task automatic frame_len(output int len, output logic [3:0] seen);
    logic p;
    len = 0;
    seen = 0;
    @(negedge clk_in);
    p = phase;
    while (phase === p && len < 20000) begin
      @(negedge clk_in);
      len++;
    end
    len = 0;
    p = phase;
    while (phase === p && len < 20000) begin
      seen |= plate;
      @(negedge clk_in);
      len++;
    end
  endtask
  // Mode to off, then a fail pulse drops the drive at once
  task automatic kill();
    axi_wr(LCM_IDX_MODE, 8'h00, LCM_RESP_OKAY);
    fail_q <= 1;
    repeat (3) @(posedge clk_in);
    fail_q <= 0;
    repeat (3) @(negedge clk_in);
    check("off", {drv, bias, plate, seg}, 0);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    axi_rd(LCM_IDX_MODE, 8'h00, LCM_RESP_OKAY);
    stall = 3;
    axi_wr(LCM_IDX_MODE, 8'hC5, LCM_RESP_OKAY);
    axi_rd(LCM_IDX_MODE, 8'hC5, LCM_RESP_OKAY);
    stall = 0;
    axi_wr(LCM_IDX_STATUS, 8'hFF, LCM_RESP_OKAY);
    axi_rd(LCM_IDX_STATUS, 8'h00, LCM_RESP_OKAY);
    axi_wr(8'hF8, 8'h77, LCM_RESP_SLVERR);
    axi_rd(8'hF8, 8'h00, LCM_RESP_SLVERR);
    check("osc off", drv, 0);
    $display("test regs done");
  endtask
  task automatic t_mux();
    int n, len;
    logic [3:0] seen;
    for (int a = 0; a < 24; a++) axi_wr(8'hE0 + 8'(a), pat(a), 2'h0);
    axi_rd(8'hE5, pat(5), LCM_RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      n = (m == 0) ? 4 : m;
      kill();
      axi_wr(LCM_IDX_MODE, {2'(m), 6'h1E}, LCM_RESP_OKAY);
      frame_len(len, seen);
      check("frame", len, n * 2048);
      check("plates", seen, (1 << n) - 1);
      check("bias", bias, m != 2);
      for (int g = 0; g < n; g++) check("seg", lit[g], segs(g));
    end
    $display("test mux done");
  endtask
  task automatic t_rate();
    int len;
    logic [3:0] seen;
    logic [7:0] bad [4] = '{8'h4F, 8'h56, 8'h46, 8'h7E};
    for (int r = 0; r < 7; r++) begin
      kill();
      axi_wr(LCM_IDX_MODE, 8'h48 | 8'(r), LCM_RESP_OKAY);
      frame_len(len, seen);
      check("base", len, 2 * ticks[r]);
    end
    axi_wr(8'hF7, 8'h5A, LCM_RESP_OKAY);
    axi_rd(8'hF7, 8'h5A, LCM_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      kill();
      axi_wr(LCM_IDX_MODE, bad[i], LCM_RESP_OKAY);
      repeat (40) @(negedge clk_in);
      check("reserved", {drv, bias}, 0);
    end
    $display("test rate done");
  endtask
  task automatic t_stop();
    int len;
    logic [3:0] seen;
    logic off;
    kill();
    axi_wr(LCM_IDX_MODE, 8'h4E, LCM_RESP_OKAY);
    frame_len(len, seen);
    @(posedge clk_in);
    stop_q <= 1; // slow source chosen first
    frame_len(len, seen);
    check("stop aux", len, 128);
    @(posedge clk_in);
    stop_q <= 0;
    kill();
    axi_wr(LCM_IDX_MODE, 8'h5E, LCM_RESP_OKAY);
    frame_len(len, seen);
    axi_wr(LCM_IDX_MODE, 8'h4E, LCM_RESP_OKAY);
    stop_q <= 1; // switch still pending
    off = 0;
    repeat (4) begin
      @(negedge clk_in);
      off |= !drv;
    end
    check("stop main", off, 1);
    @(posedge clk_in);
    stop_q <= 0;
    kill();
    $display("test stop done");
  endtask
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    sys_rst_in <= 0;
    t_regs();
    t_mux();
    t_rate();
    t_stop();
    print_verdict();
  end
  initial begin
    repeat (90000) @(posedge clk_in);
    error_cnt++;
    print_verdict();
  end
endmodule // tb_top
bind lcm_frame_ctrl lcm_frame_ctrl_properties u_chk (.clk_in(clk_in),
  .sys_rst_in(sys_rst_in), .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_rready_in(s_axi_rready_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .osc_fail_in(osc_fail_in),
  .segment_line_out(segment_line_out), .frame_phase_out(frame_phase_out),
  .backplane_outputs_out(backplane_outputs_out), .drive_en_out(drive_en_out),
  .bias_third_en_out(bias_third_en_out));

/* File: inc/lcm_pkg.sv */
// Constants for the multiplexed display frame controller
package lcm_pkg;
  // ==========================================================
  // Register map (printed offsets are indices, byte = 4x)
  localparam logic [7:0]  LCM_IDX_STATUS   = 8'h00_D0;
  localparam logic [7:0]  LCM_IDX_MODE     = 8'h00_DC;
  localparam logic [7:0]  LCM_IDX_RAM_LO   = 8'h00_E0;
  localparam logic [7:0]  LCM_IDX_RAM_HI   = 8'h00_F7;
  localparam int          LCM_RAM_BYTES    = 24;
  localparam int          LCM_GROUP_BYTES  = 6;
  localparam int          LCM_SEG_COUNT    = 45;
  localparam logic [7:0]  LCM_MODE_RST     = 8'h00_00;
  // ==========================================================
  // Mode register fields
  localparam int          LCM_MUX_POS      = 6;
  localparam int          LCM_OSC_POS      = 3;
  localparam int          LCM_RATE_POS     = 0;
  // ==========================================================
  // Multiplex ratio codes
  localparam logic [1:0]  LCM_MUX_4        = 2'h0;
  localparam logic [1:0]  LCM_MUX_1        = 2'h1;
  localparam logic [1:0]  LCM_MUX_2        = 2'h2;
  localparam logic [1:0]  LCM_MUX_3        = 2'h3;
  // ==========================================================
  // Oscillator divider codes
  localparam logic [2:0]  LCM_OSC_OFF      = 3'h0;
  localparam logic [2:0]  LCM_OSC_AUX      = 3'h1;
  localparam logic [2:0]  LCM_OSC_RSV_A    = 3'h2;
  localparam logic [2:0]  LCM_OSC_D32      = 3'h3;
  localparam logic [2:0]  LCM_OSC_D64      = 3'h4;
  localparam logic [2:0]  LCM_OSC_D128     = 3'h5;
  localparam logic [2:0]  LCM_OSC_D256     = 3'h6;
  localparam logic [2:0]  LCM_OSC_RSV_B    = 3'h7;
  localparam logic [2:0]  LCM_RATE_RSV     = 3'h7;
  // ==========================================================
  // Reference ticks per base frame for rate codes 0..6
  localparam logic [9:0]  LCM_BASE_64      = 10'h200;
  localparam logic [9:0]  LCM_BASE_85      = 10'h180;
  localparam logic [9:0]  LCM_BASE_128     = 10'h100;
  localparam logic [9:0]  LCM_BASE_171     = 10'h0C0;
  localparam logic [9:0]  LCM_BASE_256     = 10'h080;
  localparam logic [9:0]  LCM_BASE_341     = 10'h060;
  localparam logic [9:0]  LCM_BASE_512     = 10'h040;
  // ==========================================================
  // AXI responses
  localparam logic [1:0]  LCM_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  LCM_RESP_SLVERR  = 2'h2;
  // ==========================================================
  // Controller states
  typedef enum logic [1:0] {
    LCM_ST_OFF = 2'b01,
    LCM_ST_RUN = 2'b10
  } lcm_state_t;
endpackage

/* File: verilog/lcm_frame_ctrl.sv */
// Multiplexed display frame controller with AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
// Functional notes
// - Mux field 00=four, 01=one, 10=two, 11=three backplanes active.
// - At 1/1 segments refresh at base rate from divided reference.
// - Rate field 000..110 picks 64..512 Hz base; 111 is reserved.
// - Frame rate equals base rate divided by active backplane count.
// - Bias divider enable is low whenever the driver is off.
// - Third-level bias generated for 1/1, 1/3, 1/4 modes.
// - Set RAM bit drives element on, cleared bit keeps it off.
// - Display RAM is not cleared by reset.
// - Unused backplane bytes stay plain read/write storage.
// - RAM at E0..F7, six bytes per backplane, low three bits unused.
// - STOP on main oscillator switches off and grounds all outputs.
// - With auxiliary oscillator selected, scanning continues in STOP.
// - Clock source change applies only at end of current frame.
// - Mode register at DC: mux 7-6, divider 5-3, rate 2-0.
// - Divider field scales main clock to the reference tick.
// - Divider codes: off, auxiliary, /32, /64, /128, /256; 2,7 reserved.
// - Oscillator failure grounds all segment and common outputs.
module lcm_frame_ctrl
  import lcm_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     sys_rst_in,
  // AXI4-Lite write address and data
  input  wire logic [11:0]              s_axi_awaddr_in,
  input  wire logic                     s_axi_awvalid_in,
  output logic                          s_axi_awready_out,
  input  wire logic [31:0]              s_axi_wdata_in,
  input  wire logic [3:0]               s_axi_wstrb_in,
  input  wire logic                     s_axi_wvalid_in,
  output logic                          s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0]                    s_axi_bresp_out,
  output logic                          s_axi_bvalid_out,
  input  wire logic                     s_axi_bready_in,
  // AXI4-Lite read
  input  wire logic [11:0]              s_axi_araddr_in,
  input  wire logic                     s_axi_arvalid_in,
  output logic                          s_axi_arready_out,
  output logic [31:0]                   s_axi_rdata_out,
  output logic [1:0]                    s_axi_rresp_out,
  output logic                          s_axi_rvalid_out,
  input  wire logic                     s_axi_rready_in,
  // Core and oscillator status
  input  wire logic                     stop_mode_in,
  input  wire logic                     osc_fail_in,
  input  wire logic                     aux_slow_oscillator_in,
  // Panel drive
  output logic [LCM_SEG_COUNT-1:0]      segment_line_out,
  output logic [3:0]                    backplane_outputs_out,
  output logic                          frame_phase_out,
  output logic                          drive_en_out,
  output logic                          bias_third_en_out
);

  // ==========================================================
  // Registers and storage
  logic [7:0]       mode_q;
  logic [7:0]       ram_q [LCM_RAM_BYTES];
  lcm_state_t       state_q;
  logic [1:0]       act_mux_q;
  logic [2:0]       act_osc_q;
  logic [2:0]       act_rate_q;
  logic [7:0]       div_cnt_q;
  logic [9:0]       base_cnt_q;
  logic [1:0]       slot_q;
  logic             aux_q;
  logic             phase_q;
  logic             bvalid_q;
  logic [1:0]       bresp_q;
  logic             rvalid_q;
  logic [1:0]       rresp_q;
  logic [31:0]      rdata_q;
  logic [LCM_SEG_COUNT-1:0] seg_q;
  logic [3:0]       com_q;
  logic             drive_q;
  logic             bias_q;

  // ==========================================================
  // Mode decode helpers
  function automatic logic [1:0] last_slot(input logic [1:0] mux);
    unique case (mux)
      LCM_MUX_1: last_slot = 2'h0;
      LCM_MUX_2: last_slot = 2'h1;
      LCM_MUX_3: last_slot = 2'h2;
      LCM_MUX_4: last_slot = 2'h3;
    endcase
  endfunction

  function automatic logic [9:0] base_ticks(input logic [2:0] rate);
    unique case (rate)
      3'h0:    base_ticks = LCM_BASE_64;
      3'h1:    base_ticks = LCM_BASE_85;
      3'h2:    base_ticks = LCM_BASE_128;
      3'h3:    base_ticks = LCM_BASE_171;
      3'h4:    base_ticks = LCM_BASE_256;
      3'h5:    base_ticks = LCM_BASE_341;
      3'h6:    base_ticks = LCM_BASE_512;
      default: base_ticks = LCM_BASE_64;
    endcase
  endfunction

  function automatic logic [7:0] osc_last(input logic [2:0] osc);
    unique case (osc)
      LCM_OSC_D32:  osc_last = 8'h1F;
      LCM_OSC_D64:  osc_last = 8'h3F;
      LCM_OSC_D128: osc_last = 8'h7F;
      default:      osc_last = 8'hFF;
    endcase
  endfunction

  function automatic logic osc_usable(input logic [2:0] osc);
    osc_usable = (osc != LCM_OSC_OFF) && (osc != LCM_OSC_RSV_A) &&
                 (osc != LCM_OSC_RSV_B);
  endfunction

  // ==========================================================
  // Pending settings and run conditions
  logic [1:0] new_mux;
  logic [2:0] new_osc;
  logic [2:0] new_rate;
  logic       new_ok;
  logic       run_ok;
  assign new_mux  = mode_q[LCM_MUX_POS +: 2];
  assign new_osc  = mode_q[LCM_OSC_POS +: 3];
  assign new_rate = mode_q[LCM_RATE_POS +: 3];
  assign new_ok   = osc_usable(new_osc) && (new_rate != LCM_RATE_RSV);
  // Only the slow oscillator keeps ticking through STOP
  assign run_ok   = !osc_fail_in &&
                    !(stop_mode_in && act_osc_q != LCM_OSC_AUX);

  // ==========================================================
  // Reference tick: main clock divider or slow oscillator edge
  logic ref_tick;
  logic frame_end;
  logic slot_end;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      aux_q     <= 1'b0;
      div_cnt_q <= 8'h00;
    end else begin
      aux_q <= aux_slow_oscillator_in;
      if (state_q != LCM_ST_RUN || div_cnt_q == osc_last(act_osc_q))
        div_cnt_q <= 8'h00;
      else
        div_cnt_q <= div_cnt_q + 8'h01;
    end
  end
  assign ref_tick = (state_q == LCM_ST_RUN) &&
                    ((act_osc_q == LCM_OSC_AUX) ?
                     (aux_slow_oscillator_in && !aux_q) :
                     (div_cnt_q == osc_last(act_osc_q)));
  // One slot lasts one base period, so a frame of n slots runs at base/n
  assign slot_end  = ref_tick &&
                     (base_cnt_q == base_ticks(act_rate_q) - 10'h001);
  assign frame_end = slot_end && (slot_q == last_slot(act_mux_q));

  // ==========================================================
  // Slot and base counters
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      base_cnt_q <= 10'h000;
      slot_q     <= 2'h0;
      phase_q    <= 1'b0;
    end else if (state_q != LCM_ST_RUN || !run_ok) begin
      base_cnt_q <= 10'h000;
      slot_q     <= 2'h0;
      phase_q    <= 1'b0;
    end else if (ref_tick) begin
      if (slot_end) begin
        base_cnt_q <= 10'h000;
        if (frame_end) begin
          slot_q  <= 2'h0;
          phase_q <= !phase_q;
        end else begin
          slot_q <= slot_q + 2'h1;
        end
      end else begin
        base_cnt_q <= base_cnt_q + 10'h001;
      end
    end
  end

  // ==========================================================
  // Run state and settings, taken at frame ends while running or at once from off
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q    <= LCM_ST_OFF;
      act_mux_q  <= LCM_MUX_4;
      act_osc_q  <= LCM_OSC_OFF;
      act_rate_q <= 3'h0;
    end else begin
      unique case (state_q)
        LCM_ST_OFF: begin
          // Nothing is on screen, so a setting applies at once
          if (new_ok && !osc_fail_in &&
              !(stop_mode_in && new_osc != LCM_OSC_AUX)) begin
            state_q    <= LCM_ST_RUN;
            act_mux_q  <= new_mux;
            act_osc_q  <= new_osc;
            act_rate_q <= new_rate;
          end
        end
        LCM_ST_RUN: begin
          if (!run_ok) begin
            state_q   <= LCM_ST_OFF;
            act_osc_q <= LCM_OSC_OFF;
          end else if (frame_end) begin
            if (new_ok) begin
              act_mux_q  <= new_mux;
              act_osc_q  <= new_osc;
              act_rate_q <= new_rate;
            end else begin
              state_q   <= LCM_ST_OFF;
              act_osc_q <= LCM_OSC_OFF;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Segment pattern of the current slot
  logic [47:0] group_bits;
  generate
    for (genvar b = 0; b < LCM_GROUP_BYTES; b++) begin : g_grp
      assign group_bits[8*b +: 8] =
        ram_q[LCM_GROUP_BYTES * int'(slot_q) + b];
    end
  endgenerate

  // ==========================================================
  // Panel drive outputs; everything grounded while off
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      seg_q   <= '0;
      com_q   <= 4'h0;
      drive_q <= 1'b0;
      bias_q  <= 1'b0;
    end else if (state_q == LCM_ST_RUN && run_ok) begin
      // Low three bits of each group's first byte carry no segment
      seg_q   <= group_bits[47:3];
      com_q   <= 4'h1 << slot_q;
      drive_q <= 1'b1;
      bias_q  <= (act_mux_q != LCM_MUX_2);
    end else begin
      seg_q   <= '0;
      com_q   <= 4'h0;
      drive_q <= 1'b0;
      bias_q  <= 1'b0;
    end
  end
  assign segment_line_out      = seg_q;
  assign backplane_outputs_out = com_q;
  assign frame_phase_out       = phase_q;
  assign drive_en_out          = drive_q;
  assign bias_third_en_out     = bias_q;

  // ==========================================================
  // AXI4-Lite slave: write takes address and data together
  logic [9:0] wr_idx;
  logic [9:0] rd_idx;
  logic       wr_go;
  logic       rd_go;
  logic       wr_ram;
  assign wr_idx = s_axi_awaddr_in[11:2];
  assign rd_idx = s_axi_araddr_in[11:2];
  // Address and data only go in together; either alone waits
  assign wr_go  = s_axi_awvalid_in && s_axi_wvalid_in && !bvalid_q;
  assign rd_go  = s_axi_arvalid_in && !rvalid_q;
  assign wr_ram = wr_idx >= {2'b00, LCM_IDX_RAM_LO} &&
                  wr_idx <= {2'b00, LCM_IDX_RAM_HI};
  assign s_axi_awready_out = wr_go;
  assign s_axi_wready_out  = wr_go;
  assign s_axi_arready_out = rd_go;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mode_q   <= LCM_MODE_RST;
      bvalid_q <= 1'b0;
      bresp_q  <= LCM_RESP_OKAY;
    end else begin
      if (s_axi_bvalid_out && s_axi_bready_in)
        bvalid_q <= 1'b0;
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= LCM_RESP_OKAY;
        if (wr_idx == {2'b00, LCM_IDX_MODE}) begin
          if (s_axi_wstrb_in[0])
            mode_q <= s_axi_wdata_in[7:0];
        end else if (!wr_ram && wr_idx != {2'b00, LCM_IDX_STATUS}) begin
          bresp_q <= LCM_RESP_SLVERR;
        end
      end
    end
  end

  // No reset: contents are arbitrary until software writes them
  // Bytes of unused backplanes stay plain storage for software
  always_ff @(posedge clk_in) begin
    if (wr_go && wr_ram && s_axi_wstrb_in[0])
      ram_q[5'(wr_idx - {2'b00, LCM_IDX_RAM_LO})] <=
        s_axi_wdata_in[7:0];
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rvalid_q <= 1'b0;
      rresp_q  <= LCM_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else begin
      if (s_axi_rvalid_out && s_axi_rready_in)
        rvalid_q <= 1'b0;
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rresp_q  <= LCM_RESP_OKAY;
        rdata_q  <= 32'h0000_0000;
        if (rd_idx == {2'b00, LCM_IDX_MODE})
          rdata_q[7:0] <= mode_q;
        else if (rd_idx == {2'b00, LCM_IDX_STATUS})
          rdata_q[10:0] <= {slot_q, act_mux_q, act_osc_q, act_rate_q,
                            state_q == LCM_ST_RUN};
        else if (rd_idx >= {2'b00, LCM_IDX_RAM_LO} &&
                 rd_idx <= {2'b00, LCM_IDX_RAM_HI})
          rdata_q[7:0] <= ram_q[5'(rd_idx - {2'b00, LCM_IDX_RAM_LO})];
        else
          rresp_q <= LCM_RESP_SLVERR;
      end
    end
  end
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out  = bresp_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rresp_out  = rresp_q;
  assign s_axi_rdata_out  = rdata_q;

endmodule // lcm_frame_ctrl
